//--- common/alr_axil_if.sv
`timescale 1ns/100ps
// AXI4-Lite link between user master and register slave
interface alr_axil_if;
    import alrfsm_pkg::*;
    alr_addr_t awaddr;
    logic awvalid;
    logic awready;
    alr_data_t wdata;
    alr_strb_t wstrb;
    logic wvalid;
    logic wready;
    alr_resp_t bresp;
    logic bvalid;
    logic bready;
    alr_addr_t araddr;
    logic arvalid;
    logic arready;
    alr_data_t rdata;
    alr_resp_t rresp;
    logic rvalid;
    logic rready;
    // Master side
    modport master (
        output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
    // Slave side
    modport slave (
        input awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
endinterface

//--- common/alrfsm_defs.svh
`ifndef ALRFSM_DEFS_SVH
`define ALRFSM_DEFS_SVH

// Bus widths
`define ALR_ADDR_W 32
`define ALR_DATA_W 32
`define ALR_STRB_W 4
`define ALR_RESP_W 2

// Response codes
`define ALR_RESP_OKAY 2'h0
`define ALR_RESP_EXOKAY 2'h1
`define ALR_RESP_SLVERR 2'h2
`define ALR_RESP_DECERR 2'h3

// Word address field of a byte address
`define ALR_IDX_LSB 2
`define ALR_IDX_MSB 6

// Configuration space: word indices 0x00..0x0F, offsets 0x0000..0x003C
`define ALR_CFG_BASE 32'h0000_0000
`define ALR_CFG_WORDS 16
// Status space base
`define ALR_STAT_BASE 32'h0000_0200
`define ALR_STAT_WORDS 4
// Snapshot command register
`define ALR_TICK_ADDR 32'h0000_02B0
// Cycle count snapshot, low and high halves
`define ALR_CYC_LSB_ADDR 32'h0000_02B8
`define ALR_CYC_MSB_ADDR 32'h0000_02BC
// Event count snapshot, low and high halves
`define ALR_EVT_LSB_ADDR 32'h0000_02C0
`define ALR_EVT_MSB_ADDR 32'h0000_02C4

// Statistics counter width and saturation value; configuration reset value
`define ALR_CNT_W 48
`define ALR_CNT_MAX 48'hFFFF_FFFF_FFFF
`define ALR_CFG_RST 32'h0000_0000

`endif

//--- common/alrfsm_pkg.sv
package alrfsm_pkg;
    `include "alrfsm_defs.svh"
    // User side state machine states
    typedef enum logic [1:0] {
        ALR_IDLE,
        ALR_WRITE,
        ALR_READ,
        ALR_ACK
    } alr_state_t;
    // Common bus word types
    typedef logic [`ALR_ADDR_W-1:0] alr_addr_t;
    typedef logic [`ALR_DATA_W-1:0] alr_data_t;
    typedef logic [`ALR_STRB_W-1:0] alr_strb_t;
    typedef logic [`ALR_RESP_W-1:0] alr_resp_t;
endpackage

//--- logic/alr_reg_slave.sv
`timescale 1ns/100ps
`include "alrfsm_defs.svh"
// Register map slave with snapshot statistics
module alr_reg_slave (
    input wire logic clk_sys_in,
    input wire logic sreset_in,
    input wire logic stats_snapshot_pulse_in,
    input wire logic stat_event_in,
    input wire alrfsm_pkg::alr_data_t status_in [`ALR_STAT_WORDS],
    output alrfsm_pkg::alr_data_t ctl_out [`ALR_CFG_WORDS],
    alr_axil_if.slave axi
);
    import alrfsm_pkg::*;

    alr_data_t cfg_r [`ALR_CFG_WORDS]; // Configuration words
    logic [`ALR_CNT_W-1:0] cyc_acc_r; // Cycle accumulator
    logic [`ALR_CNT_W-1:0] evt_acc_r; // Event accumulator
    logic [`ALR_CNT_W-1:0] cyc_snap_r; // Readable cycle count
    logic [`ALR_CNT_W-1:0] evt_snap_r; // Readable event count
    logic bvalid_r; // Write response pending
    alr_resp_t bresp_r; // Write response code
    logic rvalid_r; // Read data pending
    alr_resp_t rresp_r; // Read response code
    alr_data_t rdata_r; // Read data word

    // Address classification; is_cfg serves reads and writes, is_stat reads only
    function automatic logic is_cfg(input alr_addr_t a);
        return (a[`ALR_ADDR_W-1:`ALR_IDX_MSB] == '0) && (a[1:0] == 2'h0);
    endfunction
    function automatic logic is_stat(input alr_addr_t a);
        return (a[`ALR_ADDR_W-1:4] == 28'(`ALR_STAT_BASE >> 4)) && (a[1:0] == 2'h0);
    endfunction

    // Write accepted only when address and data both present
    wire wr_go = axi.awvalid & axi.wvalid & ~bvalid_r;
    wire rd_go = axi.arvalid & ~rvalid_r;
    wire wr_cfg = is_cfg(axi.awaddr);
    wire wr_tick = (axi.awaddr == `ALR_TICK_ADDR);
    wire tick = (wr_go & wr_tick) | stats_snapshot_pulse_in;
    wire [3:0] cfg_idx = axi.awaddr[`ALR_IDX_MSB-1:`ALR_IDX_LSB];
    wire [3:0] rd_cidx = axi.araddr[`ALR_IDX_MSB-1:`ALR_IDX_LSB];
    wire [1:0] rd_sidx = axi.araddr[3:2];

    assign axi.awready = wr_go;
    assign axi.wready = wr_go;
    assign axi.arready = rd_go;
    assign axi.bvalid = bvalid_r;
    assign axi.bresp = bresp_r;
    assign axi.rvalid = rvalid_r;
    assign axi.rresp = rresp_r;
    assign axi.rdata = rdata_r;

    // Byte-laned configuration words
    genvar g, b;
    generate
        for (g = 0; g < `ALR_CFG_WORDS; g++) begin : g_cfg
            assign ctl_out[g] = cfg_r[g];
            for (b = 0; b < `ALR_STRB_W; b++) begin : g_lane
                always_ff @(posedge clk_sys_in) begin
                    if (sreset_in) begin
                        cfg_r[g][b*8 +: 8] <= 8'h00;
                    end else if (wr_go && wr_cfg && cfg_idx == 4'(g) && axi.wstrb[b]) begin
                        cfg_r[g][b*8 +: 8] <= axi.wdata[b*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // Write response
    always_ff @(posedge clk_sys_in) begin
        if (sreset_in) begin
            bvalid_r <= 1'b0;
            bresp_r <= `ALR_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_cfg | wr_tick) ? `ALR_RESP_OKAY : `ALR_RESP_SLVERR;
        end else if (axi.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read response and data mux
    always_ff @(posedge clk_sys_in) begin
        if (sreset_in) begin
            rvalid_r <= 1'b0;
            rresp_r <= `ALR_RESP_OKAY;
            rdata_r <= '0;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r <= `ALR_RESP_OKAY;
            if (is_cfg(axi.araddr)) begin
                rdata_r <= cfg_r[rd_cidx];
            end else if (is_stat(axi.araddr)) begin
                rdata_r <= status_in[rd_sidx];
            end else if (axi.araddr == `ALR_CYC_LSB_ADDR) begin
                rdata_r <= cyc_snap_r[31:0];
            end else if (axi.araddr == `ALR_CYC_MSB_ADDR) begin
                rdata_r <= {16'h0000, cyc_snap_r[47:32]};
            end else if (axi.araddr == `ALR_EVT_LSB_ADDR) begin
                rdata_r <= evt_snap_r[31:0];
            end else if (axi.araddr == `ALR_EVT_MSB_ADDR) begin
                rdata_r <= {16'h0000, evt_snap_r[47:32]};
            end else begin
                rdata_r <= '0;
                rresp_r <= `ALR_RESP_SLVERR;
            end
        end else if (axi.rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Saturating accumulators with snapshot on tick
    always_ff @(posedge clk_sys_in) begin
        if (sreset_in) begin
            cyc_acc_r <= '0;
            evt_acc_r <= '0;
            cyc_snap_r <= '0;
            evt_snap_r <= '0;
        end else if (tick) begin
            cyc_snap_r <= cyc_acc_r;
            evt_snap_r <= evt_acc_r;
            cyc_acc_r <= '0;
            evt_acc_r <= '0;
        end else begin
            if (cyc_acc_r != `ALR_CNT_MAX) begin
                cyc_acc_r <= cyc_acc_r + 48'h1;
            end
            if (stat_event_in && evt_acc_r != `ALR_CNT_MAX) begin
                evt_acc_r <= evt_acc_r + 48'h1;
            end
        end
    end
endmodule

//--- logic/alr_user_master.sv
`timescale 1ns/100ps
`include "alrfsm_defs.svh"
// Behaviour
// - Idle; read request first, then write
// - Write state drives address, data, strobes
// - Leave write on response handshake
// - Error response code raises write error
// - Read state drives address; leave on handshake
// - Error response code raises read error
// - Acknowledge lasts one cycle, returns idle
// - Response codes OKAY EXOKAY SLVERR DECERR
// - AXI clock, asynchronous active-low reset; slave reset synchronous active-high
// - 32-bit address and data, 4-bit strobe
// - Read ready only when data acceptable
// - Reconfig reset around port access, await alignment
// - Every control settable through configuration registers
// - Every status value readable by address
// - Unassigned holes answer with error
// - Tick write snapshots and clears accumulators
// - 48-bit saturating counters hold until tick
module alr_user_master (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic user_read_req_in,
    input wire logic user_write_req_in,
    input wire alrfsm_pkg::alr_addr_t user_addr_in,
    input wire alrfsm_pkg::alr_data_t user_wdata_in,
    input wire alrfsm_pkg::alr_strb_t user_wstrb_in,
    input wire logic user_reconfig_start_in,
    input wire logic user_reconfig_done_in,
    input wire logic rx_aligned_in,
    output logic user_busy_out,
    output logic user_ack_out,
    output logic user_write_err_out,
    output logic user_read_err_out,
    output alrfsm_pkg::alr_data_t user_rdata_out,
    output logic core_reconfig_reset_out,
    output logic reconfig_ready_out,
    alr_axil_if.master axi
);
    import alrfsm_pkg::*;

    // State, progress and payload registers
    alr_state_t state_r; // Current state
    alr_state_t state_nxt; // Next state
    logic aw_done_r; // Write address accepted
    logic w_done_r; // Write data accepted
    logic ar_done_r; // Read address accepted
    logic wr_err_r; // Sticky-until-next-request write error
    logic rd_err_r; // Read error
    alr_data_t rdata_r; // Captured read data
    alr_addr_t addr_r; // Latched request address
    alr_data_t wdata_r; // Latched write data
    alr_strb_t wstrb_r; // Latched strobes
    logic recfg_rst_r; // Core reconfiguration reset
    logic wait_align_r; // Waiting for alignment after reconfig

    // Handshake and decision wires
    wire b_fire = axi.bvalid & axi.bready;
    wire r_fire = axi.rvalid & axi.rready;
    // Requests are held off while the link realigns
    wire req_open = ~wait_align_r;
    // Start of a new transfer, payload and flags reload here
    wire start_xfer = (state_r == ALR_IDLE) && (state_nxt != ALR_IDLE);
    // Slave error codes
    wire is_err_b = (axi.bresp == `ALR_RESP_SLVERR) || (axi.bresp == `ALR_RESP_DECERR);
    wire is_err_r = (axi.rresp == `ALR_RESP_SLVERR) || (axi.rresp == `ALR_RESP_DECERR);

    // Next state decode
    always_comb begin
        // Stay put unless a branch below moves on
        state_nxt = state_r;
        case (state_r)
            ALR_IDLE: begin
                // Read wins over write; nothing taken while realigning
                if (req_open && user_read_req_in) begin
                    state_nxt = ALR_READ;
                end else if (req_open && user_write_req_in) begin
                    state_nxt = ALR_WRITE;
                end
            end
            // Wait for the write response handshake
            ALR_WRITE: begin
                if (b_fire) begin
                    state_nxt = ALR_ACK;
                end
            end
            // Wait for the read data handshake
            ALR_READ: begin
                if (r_fire) begin
                    state_nxt = ALR_ACK;
                end
            end
            // One cycle acknowledge
            ALR_ACK: state_nxt = ALR_IDLE;
            // Unused encoding recovers to idle
            default: state_nxt = ALR_IDLE;
        endcase
    end

    // Master outputs; valids held until handshake
    // Write channels
    assign axi.awvalid = (state_r == ALR_WRITE) & ~aw_done_r;
    assign axi.wvalid = (state_r == ALR_WRITE) & ~w_done_r;
    assign axi.awaddr = addr_r;
    assign axi.wdata = wdata_r;
    assign axi.wstrb = wstrb_r;
    // Response taken as soon as it shows
    assign axi.bready = (state_r == ALR_WRITE);
    // Read channels
    assign axi.arvalid = (state_r == ALR_READ) & ~ar_done_r;
    assign axi.araddr = addr_r;
    assign axi.rready = (state_r == ALR_READ);

    // User side status; busy also covers realignment
    assign user_busy_out = (state_r != ALR_IDLE) | wait_align_r;
    // Acknowledge pulse and sticky errors
    assign user_ack_out = (state_r == ALR_ACK);
    assign user_write_err_out = wr_err_r;
    assign user_read_err_out = rd_err_r;
    assign user_rdata_out = rdata_r;
    // Reconfiguration status
    assign core_reconfig_reset_out = recfg_rst_r;
    assign reconfig_ready_out = recfg_rst_r & (state_r == ALR_IDLE);

    // State register
    // Asynchronous reset parks the machine in idle
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ALR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Channel progress flags
    // Keeps each valid low once its channel has fired
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_done_r <= 1'b0;
            w_done_r <= 1'b0;
            ar_done_r <= 1'b0;
        end else if (state_r == ALR_IDLE) begin
            // Cleared between transfers
            aw_done_r <= 1'b0;
            w_done_r <= 1'b0;
            ar_done_r <= 1'b0;
        end else begin
            // Latch each accepted channel
            aw_done_r <= aw_done_r | (axi.awvalid & axi.awready);
            w_done_r <= w_done_r | (axi.wvalid & axi.wready);
            ar_done_r <= ar_done_r | (axi.arvalid & axi.arready);
        end
    end

    // Request payload capture at start
    // Payload frozen for the whole transfer
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (start_xfer) begin
            addr_r <= user_addr_in;
            wdata_r <= user_wdata_in;
            wstrb_r <= user_wstrb_in;
        end
    end

    // Error flags and read data
    // Read data kept until the next read completes
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_err_r <= 1'b0;
            rd_err_r <= 1'b0;
            rdata_r <= '0;
        end else if (start_xfer) begin
            // Fresh request clears both flags
            wr_err_r <= 1'b0;
            rd_err_r <= 1'b0;
        end else if (state_r == ALR_WRITE && b_fire) begin
            wr_err_r <= is_err_b;
        end else if (state_r == ALR_READ && r_fire) begin
            rd_err_r <= is_err_r;
            rdata_r <= axi.rdata;
        end
    end

    // Reconfiguration reset sequence
    // Reset drops only with the machine idle, so no access is cut
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            recfg_rst_r <= 1'b0;
            wait_align_r <= 1'b0;
        end else if (user_reconfig_start_in) begin
            // Start: hold the core in reset
            recfg_rst_r <= 1'b1;
            wait_align_r <= 1'b0;
        end else if (recfg_rst_r && user_reconfig_done_in && state_r == ALR_IDLE) begin
            // Done: release reset and await alignment
            recfg_rst_r <= 1'b0;
            wait_align_r <= 1'b1;
        end else if (wait_align_r && rx_aligned_in) begin
            // Aligned: requests open again
            wait_align_r <= 1'b0;
        end
    end
endmodule

//--- verification/alr_axil_chk.sv
`timescale 1ns/100ps
`include "alrfsm_defs.svh"
// Watches the link between the two ends
module alr_axil_chk (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire alrfsm_pkg::alr_addr_t awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire alrfsm_pkg::alr_data_t wdata,
    input wire alrfsm_pkg::alr_strb_t wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire alrfsm_pkg::alr_resp_t bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire alrfsm_pkg::alr_addr_t araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire alrfsm_pkg::alr_data_t rdata,
    input wire alrfsm_pkg::alr_resp_t rresp,
    input wire logic rvalid,
    input wire logic rready
);
    import alrfsm_pkg::*;
    // Writes reach configuration words and the tick command only
    function automatic logic wr_legal(input alr_addr_t a);
        return a[1:0] == 2'h0 && (a < 32'(`ALR_CFG_WORDS * 4) || a == `ALR_TICK_ADDR);
    endfunction
    // Reads reach configuration, status and snapshot words
    function automatic logic rd_legal(input alr_addr_t a);
        return a[1:0] == 2'h0 && (a < 32'(`ALR_CFG_WORDS * 4)
            || (a >= `ALR_STAT_BASE && a < `ALR_STAT_BASE + 32'(`ALR_STAT_WORDS * 4))
            || (a >= `ALR_CYC_LSB_ADDR && a <= `ALR_EVT_MSB_ADDR));
    endfunction
    wire aw_ok = wr_legal(awaddr); // Write address decodes
    wire ar_ok = rd_legal(araddr); // Read address decodes
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    sequence s_wr_acc; awvalid && awready && wvalid && wready; endsequence
    sequence s_rd_acc; arvalid && arready; endsequence
    sequence s_quiet; !awvalid && !arvalid; endsequence
    property p_aw_hold; awvalid && !awready |=> awvalid && $stable(awaddr); endproperty
    property p_w_hold; wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wstrb); endproperty
    property p_ar_hold; arvalid && !arready |=> arvalid && $stable(araddr); endproperty
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    property p_wr_resp;
        s_wr_acc |=> bvalid && bresp == ($past(aw_ok) ? `ALR_RESP_OKAY : `ALR_RESP_SLVERR);
    endproperty
    property p_rd_resp;
        s_rd_acc |=> rvalid && (($past(ar_ok) && rresp == `ALR_RESP_OKAY)
            || (!$past(ar_ok) && rresp == `ALR_RESP_SLVERR && rdata == 32'h0));
    endproperty
    property p_b_done; bvalid && bready |=> !bvalid ##0 s_quiet ##1 s_quiet; endproperty
    property p_r_done; rvalid && rready |=> !rvalid ##0 s_quiet ##1 s_quiet; endproperty
    property p_one_dir; awvalid |-> !arvalid; endproperty
    property p_rready; rvalid |-> rready; endproperty
    a_aw_hold: assert property (p_aw_hold) else $error("write address dropped early");
    a_w_hold: assert property (p_w_hold) else $error("write data dropped early");
    a_ar_hold: assert property (p_ar_hold) else $error("read address dropped early");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    a_wr_resp: assert property (p_wr_resp) else $error("bad write response");
    a_rd_resp: assert property (p_rd_resp) else $error("bad read response");
    a_b_done: assert property (p_b_done) else $error("no gap after write");
    a_r_done: assert property (p_r_done) else $error("no gap after read");
    a_one_dir: assert property (p_one_dir) else $error("read and write at once");
    a_rready: assert property (p_rready) else $error("read data not accepted");
endmodule

//--- verification/axi_lite_register_access_fsm_test.sv
`timescale 1ns/100ps
// Drives the user side of the master against the register slave
module axi_lite_register_access_fsm_test;
    import alrfsm_pkg::*;
    logic clk_sys_in = 1'b0; // System clock
    logic resetn_in = 1'b0; // Reset, active low
    logic rreq = 1'b0; // Read request
    logic wreq = 1'b0; // Write request
    alr_addr_t addr = 32'h0; // Request address
    alr_data_t wdata = 32'h0; // Write data
    alr_strb_t wstrb = 4'hF; // All lanes
    logic rc_start = 1'b0; // Reconfig start pulse
    logic rc_done = 1'b0; // Reconfig done
    logic rx_al = 1'b0; // Alignment seen
    logic snap = 1'b0; // Snapshot pulse
    logic evt = 1'b0; // Counted event
    alr_data_t stat [4]; // Status words
    alr_data_t ctl [16]; // Config words
    logic busy, ack, werr, rerr, rc_rst, rc_rdy;
    alr_data_t rdata; // Read data to user
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0; // Timeout counter
    alr_axil_if ax();
    alr_user_master i_alr_user_master (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .user_read_req_in(rreq), .user_write_req_in(wreq), .user_addr_in(addr),
        .user_wdata_in(wdata), .user_wstrb_in(wstrb), .user_reconfig_start_in(rc_start),
        .user_reconfig_done_in(rc_done), .rx_aligned_in(rx_al), .user_busy_out(busy),
        .user_ack_out(ack), .user_write_err_out(werr), .user_read_err_out(rerr),
        .user_rdata_out(rdata), .core_reconfig_reset_out(rc_rst),
        .reconfig_ready_out(rc_rdy), .axi(ax.master));
    alr_reg_slave i_alr_reg_slave (.clk_sys_in(clk_sys_in), .sreset_in(~resetn_in),
        .stats_snapshot_pulse_in(snap), .stat_event_in(evt), .status_in(stat),
        .ctl_out(ctl), .axi(ax.slave));
    alr_axil_chk i_alr_axil_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .awaddr(ax.awaddr), .awvalid(ax.awvalid), .awready(ax.awready), .wdata(ax.wdata),
        .wstrb(ax.wstrb), .wvalid(ax.wvalid), .wready(ax.wready), .bresp(ax.bresp),
        .bvalid(ax.bvalid), .bready(ax.bready), .araddr(ax.araddr), .arvalid(ax.arvalid),
        .arready(ax.arready), .rdata(ax.rdata), .rresp(ax.rresp), .rvalid(ax.rvalid),
        .rready(ax.rready));
    // Clock, 20 ns period
    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and stop
    task end_sim();
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One request: rq is {read, write}; e expected error, x expected read data
    task xfer(input logic [1:0] rq, input alr_addr_t a, input alr_data_t d,
              input logic e, input alr_data_t x);
        int n;
        n = 0;
        @(negedge clk_sys_in);
        {rreq, wreq} = rq;
        addr = a;
        wdata = d;
        @(negedge clk_sys_in);
        rreq = 1'b0;
        wreq = 1'b0;
        while (ack !== 1'b1 && n < 20) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(32'(ack), 32'h1);
        @(negedge clk_sys_in);
        chk(32'(ack), 32'h0);
        chk(32'(rq[1] ? rerr : werr), 32'(e));
        if (rq[1]) chk(rdata, x);
    endtask
    // Hang guard
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        for (int i = 0; i < 4; i++) stat[i] = 32'hA5A5_0000 + 32'(i);
        repeat (8) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        xfer(2'b01, 32'h4, 32'h1234_5678, 1'b0, 32'h0);
        chk(ctl[1], 32'h1234_5678);
        xfer(2'b10, 32'h4, 32'h0, 1'b0, 32'h1234_5678);
        xfer(2'b11, 32'h4, 32'hDEAD_BEEF, 1'b0, 32'h1234_5678);
        chk(ctl[1], 32'h1234_5678);
        wstrb = 4'h3;
        xfer(2'b01, 32'h4, 32'hAAAA_BBBB, 1'b0, 32'h0);
        wstrb = 4'hF;
        chk(ctl[1], 32'h1234_BBBB);
        xfer(2'b10, 32'h4, 32'h0, 1'b0, 32'h1234_BBBB);
        xfer(2'b01, 32'h3C, 32'hFFFF_FFFF, 1'b0, 32'h0);
        chk(ctl[15], 32'hFFFF_FFFF);
        xfer(2'b01, 32'h40, 32'h1, 1'b1, 32'h0);
        xfer(2'b01, 32'h6, 32'h1, 1'b1, 32'h0);
        xfer(2'b10, 32'h40, 32'h0, 1'b1, 32'h0);
        xfer(2'b10, 32'h3C, 32'h0, 1'b0, 32'hFFFF_FFFF);
        xfer(2'b10, 32'h210, 32'h0, 1'b1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(2'b10, 32'h200 + 32'(4 * i), 32'h0, 1'b0, 32'hA5A5_0000 + 32'(i));
        end
        // Clear, count ten events, snapshot
        xfer(2'b01, 32'h2B0, 32'h0, 1'b0, 32'h0);
        evt = 1'b1;
        repeat (10) @(negedge clk_sys_in);
        evt = 1'b0;
        xfer(2'b01, 32'h2B0, 32'h0, 1'b0, 32'h0);
        xfer(2'b10, 32'h2C0, 32'h0, 1'b0, 32'hA);
        xfer(2'b10, 32'h2C4, 32'h0, 1'b0, 32'h0);
        evt = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        evt = 1'b0;
        xfer(2'b10, 32'h2C0, 32'h0, 1'b0, 32'hA);
        snap = 1'b1;
        @(negedge clk_sys_in);
        snap = 1'b0;
        xfer(2'b10, 32'h2C0, 32'h0, 1'b0, 32'h3);
        // Reconfig reset around an access
        rc_start = 1'b1;
        @(negedge clk_sys_in);
        rc_start = 1'b0;
        chk(32'(rc_rst), 32'h1);
        chk(32'(rc_rdy), 32'h1);
        xfer(2'b01, 32'h8, 32'h5A, 1'b0, 32'h0);
        rc_done = 1'b1;
        @(negedge clk_sys_in);
        chk(32'(rc_rst), 32'h0);
        chk(32'(busy), 32'h1);
        rc_done = 1'b0;
        rx_al = 1'b1;
        @(negedge clk_sys_in);
        chk(32'(busy), 32'h0);
        xfer(2'b10, 32'h8, 32'h0, 1'b0, 32'h5A);
        end_sim();
    end
endmodule
